// [logic/pointer_channel_framer.v]
// Pointer channel parameter and key message framer with APB registers
//
// Overview of operation
// R1: Local cursor parameter opens type 0003, length 0004
// R2: local_draw_capable field reports local drawing ability
// R3: client_permits_both_cursors field reports dual permission
// R4: Host cursor parameter has type 0004, length 0004
// R5: Host reports hide_host_arrow ability
// R6: Host reports host_permits_both_cursors
// R7: Resolution parameter: type 0005, steps per inch
// R8: Icon store parameter 0006, only with local drawing
// R9: icon_store_bytes gives cache bytes, zero if none
// R10: One key message per press and per release; code merges edges of a key that occur before its message starts
// R11: Header: 00, channel id, 0C, 01, 0020
// R12: Word 2 time tag; word 3 sequence numbers
// R13: key_index 1 left, 2 right, 3 middle
// R14: key_pressed 1 on press, 0 on release
// R15: Words 4-7: index, pressed, x, y
// R16: Local drawing plus hidden host arrow: local only
// R17: Else dual if both permit, else host only; code also requires local drawing for dual
// R18: Zero icon store makes host use cache 0
// R19: Fields sent most significant byte first
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "ptr_chan_defines.vh"
module pointer_channel_framer #(
  parameter KEYS  = 3,  // Number of pointer keys
  parameter POS_W = 32  // Coordinate width
) (
  input  wire             clock,       // System clock, 25 MHz
  input  wire             reset,       // Async reset, active high
  input  wire             psel,        // APB select
  input  wire             penable,     // APB enable
  input  wire             pwrite,      // APB write
  input  wire [7:0]       paddr,       // APB byte address
  input  wire [31:0]      pwdata,      // APB write data
  output reg  [31:0]      prdata,      // APB read data
  output wire             pready,      // APB ready
  output reg              pslverr,     // APB error, unmapped address
  input  wire [KEYS-1:0]  keyLevel,    // Key levels, 1 = held down
  input  wire [POS_W-1:0] xPosition,   // Current x position
  input  wire [POS_W-1:0] yPosition,   // Current y position
  output wire [7:0]       txData,      // Byte stream toward host
  output wire             txValid,     // Byte valid
  output wire             txLast,      // Last byte of frame
  input  wire             txReady,     // Link accepts byte
  output reg  [1:0]       cursorMode   // Negotiated cursor operation
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_PARAM = 2'h1;
  localparam ST_MSG   = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // Registers

  reg [3:0]       ctrl_r;
  reg [31:0]      resol_r;
  reg [31:0]      iconStore_r;
  reg [23:0]      vcId_r;
  reg [1:0]       hostCap_r;
  reg [31:0]      timeTag_r;
  reg [15:0]      txSeq_r;
  reg [15:0]      rxSeq_r;
  reg             paramReq_r;
  reg [1:0]       state_r;
  reg [2:0]       wordIdx_r;
  reg [KEYS-1:0]  keyPrev_r;
  reg [KEYS-1:0]  pend_r;
  reg [KEYS-1:0]  pendLvl_r;
  reg [31:0]      keyIdx_r;
  reg             keyDown_r;
  reg [POS_W-1:0] xCap_r;
  reg [POS_W-1:0] yCap_r;
  reg [1:0]       capSnap_r;

  wire localDraw = ctrl_r[`CTRL_LOCAL_DRAW];
  wire bothOk    = ctrl_r[`CTRL_BOTH_CURS];
  wire keyEn     = ctrl_r[`CTRL_KEY_EN];

  wire setupPh = psel & ~penable;
  wire wrAcc   = psel & penable & pwrite;
  wire goWrite = wrAcc & (paddr == `OFS_CTRL) & pwdata[`CTRL_PARAM_GO];

  // Zero wait states keep the master simple; reads are staged at setup
  assign pready = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // Cursor operation from both sides' capabilities

  // Mode follows the registers, so a late host cap write applies on the next clock
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      cursorMode <= `MODE_HOST_ONLY;
    end else if (localDraw & hostCap_r[`HCAP_HIDE_ARROW]) begin
      cursorMode <= `MODE_LOCAL_ONLY; // [R16]
    end else if (localDraw & bothOk & hostCap_r[`HCAP_BOTH_CURS]) begin
      cursorMode <= `MODE_DUAL; // [R17]
    end else begin
      cursorMode <= `MODE_HOST_ONLY; // [R17]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Key edge detection, one pending flag per key

  wire [KEYS-1:0] keyEdge = (keyLevel ^ keyPrev_r) & {KEYS{keyEn}};
  reg  [KEYS-1:0] takeOne;
  reg  [31:0]     pickIdx;
  reg             pickLvl;
  reg             found;
  integer         k;

  // Lowest numbered key wins when several are pending
  always @* begin
    takeOne = {KEYS{1'b0}};
    pickIdx = 32'h00000000;
    pickLvl = 1'b0;
    found   = 1'b0;
    for (k = 0; k < KEYS; k = k + 1) begin
      if (pend_r[k] & ~found) begin
        found      = 1'b1;
        takeOne[k] = 1'b1;
        pickIdx    = k + 1; // [R13]
        pickLvl    = pendLvl_r[k];
      end
    end
  end

  wire startParam = (state_r == ST_IDLE) & paramReq_r;
  wire startMsg   = (state_r == ST_IDLE) & ~paramReq_r & found;

  genvar g;
  generate
    for (g = 0; g < KEYS; g = g + 1) begin : keyChan
      // A fresh edge outranks the clear of the same flag
      always @(posedge clock or posedge reset) begin
        if (reset) begin
          keyPrev_r[g] <= 1'b0;
          pend_r[g]    <= 1'b0;
          pendLvl_r[g] <= 1'b0;
        end else begin
          keyPrev_r[g] <= keyLevel[g];
          if (keyEdge[g]) begin
            pend_r[g]    <= 1'b1; // [R10]
            pendLvl_r[g] <= keyLevel[g];
          end else if (startMsg & takeOne[g]) begin
            pend_r[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Capability snapshot

  // Flags freeze at frame start so a mid-frame write cannot skip the end
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      capSnap_r <= 2'h0;
    end else if (startParam) begin
      capSnap_r <= {bothOk, localDraw}; // [R2] [R3]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Word sequencing

  reg  [31:0] wordOut;
  wire        wordReady;
  wire [2:0]  paramLast = capSnap_r[0] ? 3'h5 : 3'h3; // [R8]
  wire        inParam   = (state_r == ST_PARAM);
  wire        wordValid = (state_r != ST_IDLE);
  wire        wordLast  = inParam ? (wordIdx_r == paramLast) :
                                    (wordIdx_r == 3'h7);

  always @* begin
    wordOut = 32'h00000000;
    if (inParam) begin
      case (wordIdx_r)
        3'h0: wordOut = {`PT_LOCAL_CURSOR, `PT_LENGTH}; // [R1]
        3'h1: wordOut = {15'h0000, capSnap_r[0],
                         15'h0000, capSnap_r[1]}; // [R2] [R3]
        3'h2: wordOut = {`PT_RESOLUTION, `PT_LENGTH}; // [R7]
        3'h3: wordOut = resol_r; // [R7]
        3'h4: wordOut = {`PT_ICON_STORE, `PT_LENGTH}; // [R8]
        3'h5: wordOut = iconStore_r; // [R9]
        default: wordOut = 32'h00000000;
      endcase
    end else begin
      case (wordIdx_r)
        3'h0: wordOut = {`KM_BYTE0, vcId_r}; // [R11]
        3'h1: wordOut = {`KM_CLASS, `KM_COMMAND, `KM_LENGTH}; // [R11]
        3'h2: wordOut = timeTag_r; // [R12]
        3'h3: wordOut = {txSeq_r, rxSeq_r}; // [R12]
        3'h4: wordOut = keyIdx_r; // [R15]
        3'h5: wordOut = {31'h00000000, keyDown_r}; // [R14] [R15]
        3'h6: wordOut = xCap_r; // [R15]
        3'h7: wordOut = yCap_r; // [R15]
        default: wordOut = 32'h00000000;
      endcase
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r   <= ST_IDLE;
      wordIdx_r <= 3'h0;
      keyIdx_r  <= 32'h00000000;
      keyDown_r <= 1'b0;
      xCap_r    <= {POS_W{1'b0}};
      yCap_r    <= {POS_W{1'b0}};
    end else begin
      case (state_r)
        ST_IDLE: begin
          wordIdx_r <= 3'h0;
          if (startParam) begin
            state_r <= ST_PARAM;
          end else if (startMsg) begin
            // Position is taken when the message starts, not at the edge
            state_r   <= ST_MSG;
            keyIdx_r  <= pickIdx; // [R13]
            keyDown_r <= pickLvl; // [R14]
            xCap_r    <= xPosition; // [R15]
            yCap_r    <= yPosition; // [R15]
          end
        end
        ST_PARAM, ST_MSG: begin
          if (wordReady) begin
            wordIdx_r <= wordIdx_r + 3'h1;
            if (wordLast) begin
              state_r <= ST_IDLE;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  word_to_bytes serializer (
    .clock     (clock),
    .reset     (reset),
    .wordIn    (wordOut),
    .wordValid (wordValid),
    .wordLast  (wordLast),
    .wordReady (wordReady),
    .byteOut   (txData),
    .byteValid (txValid),
    .byteLast  (txLast),
    .byteReady (txReady)
  );

  ////////////////////////////////////////////////////////////////////////
  // APB writes

  wire msgDone = (state_r == ST_MSG) & wordReady & wordLast;

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_r      <= `RST_CTRL;
      resol_r     <= `RST_RESOL;
      iconStore_r <= `RST_ICONSTORE;
      vcId_r      <= `RST_VCID;
      hostCap_r   <= 2'h0;
      timeTag_r   <= 32'h00000000;
      txSeq_r     <= 16'h0000;
      rxSeq_r     <= 16'h0000;
      paramReq_r  <= 1'b0;
    end else begin
      // Software request outranks the clear on the start cycle
      if (goWrite) begin
        paramReq_r <= 1'b1;
      end else if (startParam) begin
        paramReq_r <= 1'b0;
      end
      if (wrAcc & (paddr == `OFS_SEQ)) begin
        txSeq_r <= pwdata[31:16];
        rxSeq_r <= pwdata[15:0];
      end else if (msgDone) begin
        txSeq_r <= txSeq_r + 16'h0001; // [R12]
      end
      // Unmapped writes fall to the default and are ignored
      if (wrAcc) begin
        case (paddr)
          // Go bit is a strobe and never stored, so it reads back as 0
          `OFS_CTRL: begin
            ctrl_r[`CTRL_LOCAL_DRAW] <= pwdata[`CTRL_LOCAL_DRAW]; // [R2]
            ctrl_r[`CTRL_BOTH_CURS]  <= pwdata[`CTRL_BOTH_CURS]; // [R3]
            ctrl_r[`CTRL_KEY_EN]     <= pwdata[`CTRL_KEY_EN];
          end
          `OFS_RESOL:     resol_r     <= pwdata;
          `OFS_ICONSTORE: iconStore_r <= pwdata; // [R9]
          `OFS_VCID:      vcId_r      <= pwdata[23:0];
          `OFS_HOSTCAP:   hostCap_r   <= pwdata[1:0]; // [R5] [R6]
          `OFS_TIMETAG:   timeTag_r   <= pwdata;
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB reads, staged in the setup cycle

  reg [31:0] rdMux;
  reg        badAddr;
  // Padding avoids a zero width replication when all eight keys exist
  wire [KEYS+7:0] pendPad = {8'h00, pend_r};

  always @* begin
    rdMux   = 32'h00000000;
    badAddr = 1'b0;
    case (paddr)
      `OFS_CTRL:      rdMux = {28'h0000000, ctrl_r[3], 1'b0, ctrl_r[1:0]};
      `OFS_RESOL:     rdMux = resol_r;
      `OFS_ICONSTORE: rdMux = iconStore_r;
      `OFS_VCID:      rdMux = {8'h00, vcId_r};
      `OFS_HOSTCAP:   rdMux = {30'h00000000, hostCap_r};
      `OFS_TIMETAG:   rdMux = timeTag_r;
      `OFS_SEQ:       rdMux = {txSeq_r, rxSeq_r};
      `OFS_STATUS: begin
        rdMux[1:0]  = cursorMode;
        rdMux[2]    = (state_r != ST_IDLE);
        rdMux[3]    = paramReq_r;
        rdMux[15:8] = pendPad[7:0];
      end
      default: badAddr = 1'b1;
    endcase
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setupPh) begin
      prdata  <= pwrite ? 32'h00000000 : rdMux;
      pslverr <= badAddr;
    end
  end

endmodule // pointer_channel_framer

// [logic/ptr_chan_defines.vh]
// Offsets, field positions, reset values and frame constants
`ifndef PTR_CHAN_DEFINES_VH
`define PTR_CHAN_DEFINES_VH

// APB register byte offsets
`define OFS_CTRL      8'h00
`define OFS_RESOL     8'h04
`define OFS_ICONSTORE 8'h08
`define OFS_VCID      8'h0C
`define OFS_HOSTCAP   8'h10
`define OFS_TIMETAG   8'h14
`define OFS_SEQ       8'h18
`define OFS_STATUS    8'h1C

// Control register fields
`define CTRL_LOCAL_DRAW  0
`define CTRL_BOTH_CURS   1
`define CTRL_PARAM_GO    2
`define CTRL_KEY_EN      3

// Host capability register fields
`define HCAP_HIDE_ARROW  0
`define HCAP_BOTH_CURS   1

// Reset values
`define RST_CTRL      4'h0
`define RST_RESOL     32'h00000000
`define RST_ICONSTORE 32'h00000000
`define RST_VCID      24'h000000

// Parameter type and length codes
`define PT_LOCAL_CURSOR 16'h0003
`define PT_HOST_CURSOR  16'h0004
`define PT_RESOLUTION   16'h0005
`define PT_ICON_STORE   16'h0006
`define PT_LENGTH       16'h0004

// Key message header bytes
`define KM_BYTE0     8'h00
`define KM_CLASS     8'h0C
`define KM_COMMAND   8'h01
`define KM_LENGTH    16'h0020

// Cursor operation encodings
`define MODE_HOST_ONLY  2'h0
`define MODE_LOCAL_ONLY 2'h1
`define MODE_DUAL       2'h2

`endif

// [logic/word_to_bytes.v]
// Splits 32-bit words into a byte stream, most significant byte first
`timescale 1ns/1ps
module word_to_bytes (
  input  wire        clock,     // System clock
  input  wire        reset,     // Async reset, active high
  input  wire [31:0] wordIn,    // Word to send
  input  wire        wordValid, // Word offered
  input  wire        wordLast,  // Word ends the frame
  output wire        wordReady, // Word accepted this cycle
  output wire [7:0]  byteOut,   // Byte to link
  output wire        byteValid, // Byte valid
  output wire        byteLast,  // Last byte of frame
  input  wire        byteReady  // Link takes byte
);

  reg [31:0] shift_r;
  reg [1:0]  cnt_r;
  reg        busy_r;
  reg        last_r;

  wire lastByte = (cnt_r == 2'h3);
  wire take     = busy_r & byteReady;

  // Next word may load in the cycle the fourth byte leaves
  assign wordReady = ~busy_r | (take & lastByte);
  assign byteOut   = shift_r[31:24]; // [R19]
  assign byteValid = busy_r;
  assign byteLast  = busy_r & last_r & lastByte;

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      shift_r <= 32'h00000000;
      cnt_r   <= 2'h0;
      busy_r  <= 1'b0;
      last_r  <= 1'b0;
    end else if (wordValid & wordReady) begin
      shift_r <= wordIn;
      cnt_r   <= 2'h0;
      busy_r  <= 1'b1;
      last_r  <= wordLast;
    end else if (take) begin
      shift_r <= {shift_r[23:0], 8'h00}; // [R19]
      cnt_r   <= cnt_r + 2'h1;
      if (lastByte) begin
        busy_r <= 1'b0;
      end
    end
  end

endmodule // word_to_bytes

// [testbench/ptr_host_sink.sv]
// Host side byte sink that captures each frame of the stream
`timescale 1ns/1ps
`include "ptr_chan_defines.vh"
module ptr_host_sink (
  input  wire         clock,              // System clock
  input  wire         reset,              // Async reset
  input  wire  [7:0]  txData,             // Byte from framer
  input  wire         txValid,            // Byte valid
  input  wire         txLast,             // Frame end
  output logic        txReady,            // Sink takes byte
  input  wire         slow,               // Stall every other cycle
  input  wire         hostHide,           // Host can hide its arrow
  input  wire         hostBoth,           // Host permits both cursors
  output logic [63:0] hostParam,          // Host cursor parameter words
  output logic [7:0]  cacheNum,           // Cache number of next icon
  output logic [7:0]  frameBytes [0:31],  // Last frame bytes
  output int          frameLen,           // Last frame length
  output int          frameCount          // Frames seen
);
  int   idx;
  logic zeroStore;
  // Software copies the host's capability word into the framer
  assign hostParam = {`PT_HOST_CURSOR, `PT_LENGTH,
                      15'h0000, hostHide, 15'h0000, hostBoth};
  // With a cache the host would start at slot 1
  assign cacheNum  = zeroStore ? 8'h00 : 8'h01;
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      txReady    <= 1'b0;
      idx        <= 0;
      zeroStore  <= 1'b1;
      frameLen   <= 0;
      frameCount <= 0;
    end else begin
      txReady <= slow ? ~txReady : 1'b1;
      if (txValid && txReady) begin
        frameBytes[idx] <= txData;
        idx <= txLast ? 0 : idx + 1;
        if (txLast) begin
          frameLen   <= idx + 1;
          frameCount <= frameCount + 1;
        end
        if (txLast && idx == 23) begin
          zeroStore <= ({frameBytes[20], frameBytes[21], frameBytes[22],
                         txData} == 32'h00000000);
        end
      end
    end
  end
endmodule // ptr_host_sink

// [testbench/pointer_channel_framer_chk.sv]
// Port level assertions for the pointer channel framer
`timescale 1ns/1ps
`include "ptr_chan_defines.vh"
module pointer_channel_framer_chk #(
  parameter KEYS  = 3,  // Number of pointer keys
  parameter POS_W = 32  // Coordinate width
) (
  input wire        clock,      // System clock
  input wire        reset,      // Async reset
  input wire        psel,       // APB select
  input wire        penable,    // APB enable
  input wire        pwrite,     // APB write
  input wire [7:0]  paddr,      // APB address
  input wire [31:0] pwdata,     // APB write data
  input wire [7:0]  txData,     // Stream byte
  input wire        txValid,    // Byte valid
  input wire        txLast,     // Frame end
  input wire        txReady,    // Sink ready
  input wire [1:0]  cursorMode  // Cursor operation
);
  default clocking dc @(posedge clock); endclocking
  default disable iff (reset);
  //////////////////////////////////////////////////
  reg  [4:0] idx_r;
  reg  [7:0] fb_r [0:31];
  reg        ld_r, bc_r, ha_r, hb_r;
  reg  [1:0] age_r;
  wire       byteTaken = txValid && txReady;
  wire       frameEnd  = byteTaken && txLast;
  wire       regWrite  = psel && penable && pwrite;
  function automatic [31:0] wordAt(input integer i);
    wordAt = {fb_r[4*i], fb_r[4*i+1], fb_r[4*i+2], fb_r[4*i+3]};
  endfunction
  // Mode checks wait for age 3 so a one cycle update lag is tolerated
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      idx_r <= 5'h00;
      {ld_r, bc_r, ha_r, hb_r} <= 4'h0;
      age_r <= 2'h0;
    end else begin
      if (byteTaken) begin
        fb_r[idx_r] <= txData;
        idx_r <= txLast ? 5'h00 : idx_r + 5'h01;
      end
      age_r <= (age_r == 2'h3) ? 2'h3 : age_r + 2'h1;
      if (regWrite && paddr == `OFS_CTRL) begin
        {bc_r, ld_r} <= pwdata[1:0];
        age_r <= 2'h0;
      end
      if (regWrite && paddr == `OFS_HOSTCAP) begin
        {hb_r, ha_r} <= pwdata[1:0];
        age_r <= 2'h0;
      end
    end
  end
  //////////////////////////////////////////////////
  sequence heldByte;
    txValid && $stable(txData) && $stable(txLast);
  endsequence
  AST_HOLD: assert property (txValid && !txReady |=> heldByte)
    else $error("stream byte changed while stalled");
  AST_LEN: assert property (frameEnd |-> idx_r == 5'h0F ||
    idx_r == 5'h17 || idx_r == 5'h1F) else $error("bad frame length");
  AST_PARAM_HDR: assert property (frameEnd && idx_r != 5'h1F |->
    wordAt(0) == 32'h00030004 && wordAt(2) == 32'h00050004)
    else $error("parameter type or length wrong");
  AST_PARAM_FLAGS: assert property (frameEnd && idx_r != 5'h1F |->
    wordAt(1) == {15'h0000, ld_r, 15'h0000, bc_r})
    else $error("capability flags wrong");
  AST_ICON: assert property (frameEnd && idx_r != 5'h1F |->
    (ld_r ? idx_r == 5'h17 && wordAt(4) == 32'h00060004 : idx_r == 5'h0F))
    else $error("icon store parameter misplaced");
  AST_KEY_HDR: assert property (frameEnd && idx_r == 5'h1F |->
    fb_r[0] == 8'h00 && wordAt(1) == 32'h0C010020)
    else $error("key message header wrong");
  AST_KEY_FIELDS: assert property (frameEnd && idx_r == 5'h1F |->
    wordAt(4) >= 1 && wordAt(4) <= KEYS && wordAt(5) <= 1)
    else $error("key index or pressed field wrong");
  AST_MODE_LOCAL: assert property (age_r == 2'h3 && ld_r && ha_r |->
    cursorMode == 2'h1) else $error("local only mode not chosen");
  AST_MODE_DUAL: assert property (age_r == 2'h3 && ld_r && !ha_r |->
    cursorMode == ((bc_r && hb_r) ? 2'h2 : 2'h0))
    else $error("dual or host mode wrong");
  AST_MODE_OFF: assert property (age_r == 2'h3 && !ld_r |->
    cursorMode == 2'h0) else $error("mode without local drawing");
endmodule // pointer_channel_framer_chk
bind pointer_channel_framer pointer_channel_framer_chk #(.KEYS(KEYS),
  .POS_W(POS_W)) chk (.clock(clock), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .txData(txData), .txValid(txValid), .txLast(txLast),
  .txReady(txReady), .cursorMode(cursorMode));

// [testbench/pointer_channel_param_and_button_pdu_tb_top.sv]
// Register and stream tests for the pointer channel framer
`timescale 1ns/1ps
`include "ptr_chan_defines.vh"
module pointer_channel_param_and_button_pdu_tb_top;
  logic        clock, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, txData;
  logic [31:0] pwdata, prdata, xPosition, yPosition, rdData;
  logic [2:0]  keyLevel;
  logic        txValid, txLast, txReady, slow, rdErr;
  logic [1:0]  cursorMode;
  logic [7:0]  frameBytes [0:31];
  logic [63:0] hostParam;
  logic [7:0]  cacheNum;
  logic        hostHide, hostBoth;
  int          frameLen, frameCount, errors, n_checks, c, k;
  pointer_channel_framer uut (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .keyLevel(keyLevel), .xPosition(xPosition), .yPosition(yPosition),
    .txData(txData), .txValid(txValid), .txLast(txLast),
    .txReady(txReady), .cursorMode(cursorMode));
  ptr_host_sink host (.clock(clock), .reset(reset), .txData(txData),
    .txValid(txValid), .txLast(txLast), .txReady(txReady), .slow(slow),
    .hostHide(hostHide), .hostBoth(hostBoth), .hostParam(hostParam),
    .cacheNum(cacheNum), .frameBytes(frameBytes), .frameLen(frameLen),
    .frameCount(frameCount));
  always #20 clock = ~clock;
  //////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Holds the request until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clock);
      n++;
    end
    if (n == 50) chk(1'b0, 1'b1);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic er);
    apb(1'b0, a, 32'h00000000);
    chk(rdData, e);
    chk(rdErr, er);
  endtask
  task automatic getFrame(input int len);
    int c0, n;
    c0 = frameCount;
    n = 0;
    while (frameCount == c0 && n < 500) begin
      @(posedge clock);
      n++;
    end
    chk(frameCount != c0, 1'b1);
    chk(frameLen, len);
  endtask
  function automatic logic [31:0] hostCaps();
    return {30'h00000000, hostParam[0], hostParam[16]};
  endfunction
  function automatic logic [31:0] fw(input int i);
    return {frameBytes[4*i], frameBytes[4*i+1], frameBytes[4*i+2],
            frameBytes[4*i+3]};
  endfunction
  task automatic print_verdict;
    if (errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  //////////////////////////////////////////////////
  initial begin
    #(40 * 20000);
    errors++;
    print_verdict;
  end
  initial begin
    clock = 0;
    reset = 1;
    psel = 0;
    penable = 0;
    pwrite = 0;
    slow = 0;
    paddr = 0;
    pwdata = 0;
    keyLevel = 0;
    xPosition = 0;
    yPosition = 0;
    hostHide = 0;
    hostBoth = 0;
    errors = 0;
    n_checks = 0;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rd(`OFS_CTRL, 32'h00000000, 1'b0);
    rd(`OFS_RESOL, 32'h00000000, 1'b0);
    rd(`OFS_ICONSTORE, 32'h00000000, 1'b0);
    rd(8'h20, 32'h00000000, 1'b1);
    apb(1'b1, `OFS_RESOL, 32'h12345678);
    apb(1'b1, `OFS_CTRL, 32'h00000006);
    getFrame(16);
    chk(fw(0), 32'h00030004);
    chk(fw(1), 32'h00000001);
    chk(fw(2), 32'h00050004);
    chk(fw(3), 32'h12345678);
    chk(cursorMode, 2'h0);
    slow <= 1'b1;
    hostBoth <= 1'b1;
    apb(1'b1, `OFS_ICONSTORE, 32'h00000400);
    chk(hostParam[63:32], 32'h00040004);
    apb(1'b1, `OFS_HOSTCAP, hostCaps());
    apb(1'b1, `OFS_CTRL, 32'h00000007);
    getFrame(24);
    chk(fw(1), 32'h00010001);
    chk(fw(4), 32'h00060004);
    chk(fw(5), 32'h00000400);
    chk(cacheNum, 8'h01);
    chk(cursorMode, 2'h2);
    slow <= 1'b0;
    hostHide <= 1'b1;
    hostBoth <= 1'b0;
    apb(1'b1, `OFS_ICONSTORE, 32'h00000000);
    apb(1'b1, `OFS_CTRL, 32'h00000005);
    getFrame(24);
    chk(fw(1), 32'h00010000);
    chk(fw(5), 32'h00000000);
    chk(cacheNum, 8'h00);
    chk(cursorMode, 2'h0);
    apb(1'b1, `OFS_HOSTCAP, hostCaps());
    repeat (2) @(posedge clock);
    chk(cursorMode, 2'h1);
    rd(`OFS_STATUS, 32'h00000001, 1'b0);
    apb(1'b1, `OFS_VCID, 32'h00ABCDEF);
    apb(1'b1, `OFS_TIMETAG, 32'h11223344);
    apb(1'b1, `OFS_SEQ, 32'h00050009);
    yPosition <= 32'h00000200;
    c = frameCount;
    keyLevel <= 3'h1;
    repeat (40) @(posedge clock);
    chk(frameCount, c);
    keyLevel <= 3'h0;
    repeat (3) @(posedge clock);
    apb(1'b1, `OFS_CTRL, 32'h00000009);
    for (k = 0; k < 6; k++) begin
      xPosition <= 32'h00000100 + k;
      keyLevel[k % 3] <= (k < 3);
      getFrame(32);
      chk(fw(0), 32'h00ABCDEF);
      chk(fw(1), 32'h0C010020);
      chk(fw(2), 32'h11223344);
      chk(fw(3), {16'h0005 + k[15:0], 16'h0009});
      chk(fw(4), (k % 3) + 1);
      chk(fw(5), k < 3);
      chk(fw(6), 32'h00000100 + k);
      chk(fw(7), 32'h00000200);
    end
    repeat (50) @(posedge clock);
    chk(frameCount, c + 6);
    rd(`OFS_SEQ, 32'h000B0009, 1'b0);
    print_verdict;
  end
endmodule // pointer_channel_param_and_button_pdu_tb_top
